// ---- design/tcp_pkg.sv ----
// package for the single-slope 16-bit timer: register map, modes, actions, reset values
// assumes an apb slave with 32-bit data; one register per aligned word
package tcp_pkg;
  // ------------------------------------------------------------------
  // register offsets (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] TCP_OFS_CTRL    = 8'h00; // mode, actions, prescale, direction
  localparam logic [7:0] TCP_OFS_CMPA    = 8'h04; // compare_a_value (buffer in pwm)
  localparam logic [7:0] TCP_OFS_CMPB    = 8'h08; // compare_b_value
  localparam logic [7:0] TCP_OFS_CAPTOP  = 8'h0C; // capture_top_value
  localparam logic [7:0] TCP_OFS_COUNT   = 8'h10; // counter_value, read only
  localparam logic [7:0] TCP_OFS_FLAGS   = 8'h14; // sticky flags, write one to clear
  localparam logic [7:0] TCP_OFS_CMPA_ACT = 8'h18; // active compare a, read only
  // ------------------------------------------------------------------
  // control field positions
  // ------------------------------------------------------------------
  localparam int TCP_CTRL_MODE_LSB = 0;   // waveform_mode_select [3:0]
  localparam int TCP_CTRL_ACTA_LSB = 4;   // output_action_select_a [5:4]
  localparam int TCP_CTRL_ACTB_LSB = 6;   // output_action_select_b [7:6]
  localparam int TCP_CTRL_PRE_LSB  = 8;   // prescale select [10:8]
  localparam int TCP_CTRL_DIRA     = 12;  // pin_direction_bit a
  localparam int TCP_CTRL_DIRB     = 13;  // pin_direction_bit b
  // flag bit positions
  localparam int TCP_FLG_OVF  = 0;
  localparam int TCP_FLG_CMPA = 1;
  localparam int TCP_FLG_CMPB = 2;
  localparam int TCP_FLG_CAP  = 3;
  // ------------------------------------------------------------------
  // modes, actions, constants
  // ------------------------------------------------------------------
  localparam logic [3:0] TCP_MODE_CTC_A  = 4'h4;
  localparam logic [3:0] TCP_MODE_FP8    = 4'h5;
  localparam logic [3:0] TCP_MODE_FP9    = 4'h6;
  localparam logic [3:0] TCP_MODE_FP10   = 4'h7;
  localparam logic [3:0] TCP_MODE_CTC_C  = 4'hC;
  localparam logic [3:0] TCP_MODE_FP_CAP = 4'hE;
  localparam logic [3:0] TCP_MODE_FP_A   = 4'hF;
  localparam logic [1:0] TCP_ACT_NONE    = 2'h0;
  localparam logic [1:0] TCP_ACT_TOGGLE  = 2'h1;
  localparam logic [1:0] TCP_ACT_INV     = 2'h2; // fast pwm: inverted
  localparam logic [1:0] TCP_ACT_NONINV  = 2'h3; // fast pwm: non-inverted
  localparam logic [15:0] TCP_TOP_8      = 16'h00FF;
  localparam logic [15:0] TCP_TOP_9      = 16'h01FF;
  localparam logic [15:0] TCP_TOP_10     = 16'h03FF;
  localparam logic [15:0] TCP_MAX        = 16'hFFFF;
  localparam logic [15:0] TCP_BOTTOM     = 16'h0000;
  // prescale select codes: 0 stopped, then 1, 8, 64, 256, 1024
  localparam logic [2:0] TCP_PRE_STOP = 3'h0;
  localparam logic [2:0] TCP_PRE_1    = 3'h1;
  localparam logic [2:0] TCP_PRE_8    = 3'h2;
  localparam logic [2:0] TCP_PRE_64   = 3'h3;
  localparam logic [2:0] TCP_PRE_256  = 3'h4;
  localparam logic [2:0] TCP_PRE_1024 = 3'h5;
  localparam logic [9:0] TCP_DIV_8    = 10'h007; // terminal counts of the prescaler
  localparam logic [9:0] TCP_DIV_64   = 10'h03F;
  localparam logic [9:0] TCP_DIV_256  = 10'h0FF;
  localparam logic [9:0] TCP_DIV_1024 = 10'h3FF;
  localparam logic [31:0] TCP_CTRL_RESET = 32'h0000_0000;
endpackage

// ---- design/tcp_timer.sv ----
// 16-bit single-slope timer: clear-on-match and fast pwm, two compare channels
// assumes an apb master on clk, synchronous inputs, asynchronous active-high reset
//
// Local design decisions: the APB slave port and the register offsets.
module tcp_timer (
  input  wire logic        clk,      // 200 MHz i/o clock
  input  wire logic        reset,    // asynchronous, active high
  input  wire logic        psel,     // apb select
  input  wire logic        penable,  // apb access phase
  input  wire logic        pwrite,   // apb direction
  input  wire logic [7:0]  paddr,    // apb byte address
  input  wire logic [31:0] pwdata,   // apb write data
  output logic      [31:0] prdata,   // apb read data
  output logic             pready,   // apb ready
  output logic             pslverr,  // apb error, unmapped address
  output logic             pin_a_out, // wave_out_a pin level
  output logic             pin_a_oe_n, // low while pin a is driven
  output logic             pin_b_out, // wave_out_b pin level
  output logic             pin_b_oe_n  // low while pin b is driven
);
  // ------------------------------------------------------------------
  // registers and apb decode
  // ------------------------------------------------------------------
  logic [31:0] ctrl;
  logic [15:0] cmp_buf [2];   // software-visible compare values
  logic [15:0] cmp_act [2];   // active compare values
  logic [15:0] cap_top;
  logic [15:0] counter_value;
  logic [3:0]  flags;
  logic [1:0]  wave_out;
  logic [9:0]  pre_cnt;

  wire access   = psel & penable;
  // a write lands only at the ready edge, so a write-one clear acts once
  wire wr       = access & pwrite & pready;
  wire hit_ctrl = paddr == tcp_pkg::TCP_OFS_CTRL;
  wire hit_cmpa = paddr == tcp_pkg::TCP_OFS_CMPA;
  wire hit_cmpb = paddr == tcp_pkg::TCP_OFS_CMPB;
  wire hit_cap  = paddr == tcp_pkg::TCP_OFS_CAPTOP;
  wire hit_cnt  = paddr == tcp_pkg::TCP_OFS_COUNT;
  wire hit_flg  = paddr == tcp_pkg::TCP_OFS_FLAGS;
  wire hit_act  = paddr == tcp_pkg::TCP_OFS_CMPA_ACT;
  wire mapped   = hit_ctrl | hit_cmpa | hit_cmpb | hit_cap | hit_cnt | hit_flg | hit_act;

  wire [3:0] waveform_mode_select = ctrl[tcp_pkg::TCP_CTRL_MODE_LSB +: 4];
  wire [1:0] act [2];
  assign act[0] = ctrl[tcp_pkg::TCP_CTRL_ACTA_LSB +: 2];
  assign act[1] = ctrl[tcp_pkg::TCP_CTRL_ACTB_LSB +: 2];
  wire [2:0] pre_sel = ctrl[tcp_pkg::TCP_CTRL_PRE_LSB +: 3];
  wire [1:0] pin_direction_bit = {ctrl[tcp_pkg::TCP_CTRL_DIRB], ctrl[tcp_pkg::TCP_CTRL_DIRA]};

  // ------------------------------------------------------------------
  // mode decode and top selection
  // ------------------------------------------------------------------
  wire mode_ctc_a = waveform_mode_select == tcp_pkg::TCP_MODE_CTC_A;
  wire mode_ctc_c = waveform_mode_select == tcp_pkg::TCP_MODE_CTC_C;
  wire mode_ctc   = mode_ctc_a | mode_ctc_c;
  wire mode_fp8   = waveform_mode_select == tcp_pkg::TCP_MODE_FP8;
  wire mode_fp9   = waveform_mode_select == tcp_pkg::TCP_MODE_FP9;
  wire mode_fp10  = waveform_mode_select == tcp_pkg::TCP_MODE_FP10;
  wire mode_fpc   = waveform_mode_select == tcp_pkg::TCP_MODE_FP_CAP;
  wire mode_fpa   = waveform_mode_select == tcp_pkg::TCP_MODE_FP_A;
  wire fixed_top  = mode_fp8 | mode_fp9 | mode_fp10;
  wire mode_fast  = fixed_top | mode_fpc | mode_fpa;
  // single-slope top; other modes run free to max
  wire [15:0] top_value =
    mode_fp8 ? tcp_pkg::TCP_TOP_8 :
    mode_fp9 ? tcp_pkg::TCP_TOP_9 :
    mode_fp10 ? tcp_pkg::TCP_TOP_10 :
    (mode_ctc_c | mode_fpc) ? cap_top :
    (mode_ctc_a | mode_fpa) ? cmp_act[0] :
    tcp_pkg::TCP_MAX;
  // fixed tops keep only the resolution's low bits of a written compare
  wire [15:0] cmp_mask =
    mode_fp8 ? tcp_pkg::TCP_TOP_8 :
    mode_fp9 ? tcp_pkg::TCP_TOP_9 :
    mode_fp10 ? tcp_pkg::TCP_TOP_10 : tcp_pkg::TCP_MAX;
  wire [15:0] cmp_wdata = pwdata[15:0] & cmp_mask;

  // ------------------------------------------------------------------
  // prescaler: one tick every N clocks, N = 1, 8, 64, 256 or 1024
  // ------------------------------------------------------------------
  wire [9:0] pre_term =
    (pre_sel == tcp_pkg::TCP_PRE_8)    ? tcp_pkg::TCP_DIV_8 :
    (pre_sel == tcp_pkg::TCP_PRE_64)   ? tcp_pkg::TCP_DIV_64 :
    (pre_sel == tcp_pkg::TCP_PRE_256)  ? tcp_pkg::TCP_DIV_256 :
    (pre_sel == tcp_pkg::TCP_PRE_1024) ? tcp_pkg::TCP_DIV_1024 : 10'h000;
  wire pre_valid = (pre_sel != tcp_pkg::TCP_PRE_STOP) & (pre_sel <= tcp_pkg::TCP_PRE_1024);
  wire tick      = pre_valid & (pre_cnt >= pre_term);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) pre_cnt <= 10'h000;
    else if (!pre_valid || tick) pre_cnt <= 10'h000;
    else pre_cnt <= pre_cnt + 10'h001;
  end

  // ------------------------------------------------------------------
  // counter: equality with top clears, otherwise counts up and wraps
  // ------------------------------------------------------------------
  wire at_top   = counter_value == top_value;
  wire at_max   = counter_value == tcp_pkg::TCP_MAX;
  // a top below the count is missed, so the count runs on through max
  wire top_hit  = (mode_ctc | mode_fast) & at_top;
  wire [15:0] next_count = top_hit ? tcp_pkg::TCP_BOTTOM
                                   : counter_value + 16'h0001;
  wire ovf_evt  = mode_fast ? top_hit : at_max;
  wire wrap     = mode_fast & top_hit;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) counter_value <= tcp_pkg::TCP_BOTTOM;
    else if (tick) counter_value <= next_count;
  end

  // ------------------------------------------------------------------
  // per-channel compare, buffering and waveform
  // ------------------------------------------------------------------
  logic [1:0] match;
  logic [1:0] next_wave;
  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    wire wr_cmp = wr & (ch == 0 ? hit_cmpa : hit_cmpb);
    // the top-defining channel matches on every period in fast pwm; in clear-on-match a write below the count waits for the wrap through max
    assign match[ch] = counter_value == cmp_act[ch];
    wire toggle_ok = (ch == 0) & (mode_ctc_a | mode_ctc_c | mode_fpa);
    always_comb begin
      next_wave[ch] = wave_out[ch];
      if (mode_fast && act[ch] >= tcp_pkg::TCP_ACT_INV) begin
        // inverted sets on match; non-inverted clears; bottom does the opposite
        if (match[ch]) next_wave[ch] = (act[ch] == tcp_pkg::TCP_ACT_INV);
        else if (wrap) next_wave[ch] = (act[ch] == tcp_pkg::TCP_ACT_NONINV);
      end else if (act[ch] == tcp_pkg::TCP_ACT_TOGGLE && toggle_ok && match[ch]) begin
        next_wave[ch] = ~wave_out[ch];
      end else if (!mode_fast && match[ch]) begin
        if (act[ch] == tcp_pkg::TCP_ACT_INV) next_wave[ch] = 1'b0;
        else if (act[ch] == tcp_pkg::TCP_ACT_NONINV) next_wave[ch] = 1'b1;
      end
    end
    always_ff @(posedge clk or posedge reset) begin
      if (reset) cmp_buf[ch] <= 16'h0000;
      else if (wr_cmp) cmp_buf[ch] <= cmp_wdata;
    end
    // pwm: active value loads at top; otherwise writes go straight through
    always_ff @(posedge clk or posedge reset) begin
      if (reset) cmp_act[ch] <= 16'h0000;
      else if (!mode_fast && wr_cmp) cmp_act[ch] <= cmp_wdata;
      else if (mode_fast && tick && top_hit) cmp_act[ch] <= cmp_buf[ch];
      else if (!mode_fast) cmp_act[ch] <= cmp_buf[ch];
    end
    always_ff @(posedge clk or posedge reset) begin
      if (reset) wave_out[ch] <= 1'b0;
      else if (tick) wave_out[ch] <= next_wave[ch];
    end
  end

  // ------------------------------------------------------------------
  // control and capture-top registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) ctrl <= tcp_pkg::TCP_CTRL_RESET;
    else if (wr && hit_ctrl) ctrl <= pwdata;
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) cap_top <= 16'h0000;
    else if (wr && hit_cap) cap_top <= pwdata[15:0];
  end

  // ------------------------------------------------------------------
  // sticky flags: hardware set wins over a write-one clear
  // ------------------------------------------------------------------
  logic [3:0] set_flags;
  always_comb begin
    set_flags = 4'h0;
    set_flags[tcp_pkg::TCP_FLG_OVF]  = tick & ovf_evt;
    set_flags[tcp_pkg::TCP_FLG_CMPA] = tick & match[0];
    set_flags[tcp_pkg::TCP_FLG_CMPB] = tick & match[1];
    set_flags[tcp_pkg::TCP_FLG_CAP]  = tick & top_hit & (mode_ctc_c | mode_fpc);
  end
  wire [3:0] clr_flags = (wr && hit_flg) ? pwdata[3:0] : 4'h0;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) flags <= 4'h0;
    else flags <= (flags & ~clr_flags) | set_flags;
  end

  // ------------------------------------------------------------------
  // read mux; registered data, one wait state so every answer is a flop
  // ------------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl) rd_mux = {18'h0, ctrl[13:0]};
    if (hit_cmpa) rd_mux = {16'h0000, cmp_buf[0]};
    if (hit_cmpb) rd_mux = {16'h0000, cmp_buf[1]};
    if (hit_cap) rd_mux = {16'h0000, cap_top};
    if (hit_cnt) rd_mux = {16'h0000, counter_value};
    if (hit_flg) rd_mux = {28'h0000000, flags};
    if (hit_act) rd_mux = {16'h0000, cmp_act[0]};
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= access & ~pready;
      prdata  <= rd_mux;
      pslverr <= access & ~pready & ~mapped;
    end
  end

  // pins: waveform only while direction selects output
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_a_out  <= 1'b0;
      pin_b_out  <= 1'b0;
      pin_a_oe_n <= 1'b1;
      pin_b_oe_n <= 1'b1;
    end else begin
      pin_a_out  <= next_wave[0] & tick | wave_out[0] & ~tick;
      pin_b_out  <= next_wave[1] & tick | wave_out[1] & ~tick;
      pin_a_oe_n <= ~(pin_direction_bit[0] & (act[0] != tcp_pkg::TCP_ACT_NONE));
      pin_b_oe_n <= ~(pin_direction_bit[1] & (act[1] != tcp_pkg::TCP_ACT_NONE));
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  chk_ctc_clear: assert property (@(posedge clk) disable iff (reset)
    tick && mode_ctc && at_top |=> counter_value == 16'h0000)
    else $error("counter not cleared at top");
  chk_ovf_max: assert property (@(posedge clk) disable iff (reset)
    tick && mode_ctc && at_max |=> flags[0])
    else $error("overflow flag missed at max");
  chk_fast_clear: assert property (@(posedge clk) disable iff (reset)
    tick && mode_fast && at_top |=> counter_value == 16'h0000 && flags[0])
    else $error("fast pwm did not clear after top");
  chk_up_only: assert property (@(posedge clk) disable iff (reset)
    tick && mode_fast && !at_top |=> counter_value == $past(counter_value) + 16'h0001)
    else $error("fast pwm counter not counting up");
  chk_toggle_a: assert property (@(posedge clk) disable iff (reset)
    tick && mode_ctc_a && act[0] == 2'h1 && match[0] |=> wave_out[0] != $past(wave_out[0]))
    else $error("toggle missed on match");
  chk_noninv_bottom: assert property (@(posedge clk) disable iff (reset)
    tick && mode_fast && act[0] == 2'h3 && top_hit && !match[0] |=> wave_out[0])
    else $error("non-inverted not set at bottom");
  chk_buf_load: assert property (@(posedge clk) disable iff (reset)
    tick && mode_fast && top_hit |=> cmp_act[0] == $past(cmp_buf[0]))
    else $error("compare buffer not loaded at top");
  chk_pin_hidden: assert property (@(posedge clk) disable iff (reset)
    !pin_direction_bit[0] |=> pin_a_oe_n)
    else $error("pin driven without direction");
  chk_hold_none: assert property (@(posedge clk) disable iff (reset)
    act[0] == 2'h0 && !reset ##1 act[0] == 2'h0 |-> wave_out[0] == $past(wave_out[0]))
    else $error("waveform changed with no action");

  // flags raised at top in both families and on compare b match in fast pwm; the nine-bit top clear
  chk_ctc_flag_a: assert property (@(posedge clk) disable iff (reset)
    tick && mode_ctc_a && at_top |=> flags[1])
    else $error("compare a flag missed at top");

  chk_ctc_flag_cap: assert property (@(posedge clk) disable iff (reset)
    tick && mode_ctc_c && at_top |=> flags[3])
    else $error("capture flag missed at top");

  chk_fast_cap_flag: assert property (@(posedge clk) disable iff (reset)
    tick && mode_fpc && at_top |=> flags[3] && flags[0])
    else $error("fast pwm top flags missed");

  chk_cmp_flag_b: assert property (@(posedge clk) disable iff (reset)
    tick && mode_fast && match[1] |=> flags[2])
    else $error("compare b flag missed");

  chk_fixed_top: assert property (@(posedge clk) disable iff (reset)
    tick && mode_fp9 && counter_value == 16'h01FF |=> counter_value == 16'h0000)
    else $error("nine-bit top not honoured");

  // pins and register writes
  chk_pin_follow: assert property (@(posedge clk) disable iff (reset)
    pin_a_out == wave_out[0] && pin_b_out == wave_out[1])
    else $error("pin level differs from waveform");

  chk_pin_driven: assert property (@(posedge clk) disable iff (reset)
    pin_direction_bit[0] && act[0] != 2'h0 |=> !pin_a_oe_n)
    else $error("pin not driven with direction set");

  chk_mask_fixed: assert property (@(posedge clk) disable iff (reset)
    wr && hit_cmpa && mode_fp8 |=> cmp_buf[0][15:8] == 8'h00)
    else $error("compare high bits kept at fixed top");

  chk_cap_direct: assert property (@(posedge clk) disable iff (reset)
    wr && hit_cap |=> cap_top == $past(pwdata[15:0]))
    else $error("capture top not written at once");

  chk_ctc_direct: assert property (@(posedge clk) disable iff (reset)
    wr && hit_cmpa && mode_ctc |=> cmp_act[0] == $past(pwdata[15:0]))
    else $error("clear-on-match top buffered");

  // waveform actions and buffering
  chk_buf_hold: assert property (@(posedge clk) disable iff (reset)
    mode_fast && !(tick && top_hit) |=> cmp_act[0] == $past(cmp_act[0]))
    else $error("active compare changed between tops");

  chk_inv_match: assert property (@(posedge clk) disable iff (reset)
    tick && mode_fast && act[0] == 2'h2 && match[0] |=> wave_out[0])
    else $error("inverted not set on match");

  chk_noninv_match: assert property (@(posedge clk) disable iff (reset)
    tick && mode_fast && act[0] == 2'h3 && match[0] |=> !wave_out[0])
    else $error("non-inverted not cleared on match");

  chk_toggle_fpa: assert property (@(posedge clk) disable iff (reset)
    tick && mode_fpa && act[0] == 2'h1 && match[0] |=> wave_out[0] != $past(wave_out[0]))
    else $error("mode f toggle missed");

  cov_ctc_wrap: cover property (@(posedge clk) disable iff (reset) tick && mode_ctc && top_hit);
  cov_fast_top: cover property (@(posedge clk) disable iff (reset) tick && mode_fpa && top_hit);
  cov_cap_top: cover property (@(posedge clk) disable iff (reset) tick && mode_fpc && top_hit);
  cov_fixed_top: cover property (@(posedge clk) disable iff (reset) tick && fixed_top && top_hit);
  cov_ctc_miss: cover property (@(posedge clk) disable iff (reset) tick && mode_ctc && at_max);
endmodule

// ---- tb/tcp_apb_master.sv ----
// apb master standing in for processor software on the timer's register bus
// assumes a slave that answers with pready; calls are made just after a rising edge
module tcp_apb_master (
  input  wire logic        clk,     // bus clock
  input  wire logic        pready,  // slave ready
  output logic             psel,    // select
  output logic             penable, // access phase
  output logic             pwrite,  // direction
  output logic [7:0]       paddr,   // byte address
  output logic [31:0]      pwdata   // write data
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------------
  // bus idle at time zero
  // ------------------------------------------------------------------
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end
  // one transfer; release waits one edge so back-to-back calls never double-drive psel
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1); // a slow slave just stretches the access
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
endmodule

// ---- tb/tcp_timer_tb_top.sv ----
// self-checking bench for the single-slope timer: apb stimulus, read monitor, pin timing
// assumes the apb master model; pin a levels are timed on the falling edge, mid-cycle; enables and pin b are checked just after a rising edge
module tcp_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] exp; logic [31:0] mask; logic err;} tcp_note_t;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pin_a_out, pin_a_oe_n, pin_b_out, pin_b_oe_n;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int t, v, c, hi, lo;
  tcp_note_t notes[$];
  tcp_note_t nt;
  logic [15:0] tops [3] = '{tcp_pkg::TCP_TOP_8, tcp_pkg::TCP_TOP_9, tcp_pkg::TCP_TOP_10};

  always #2.5 clk = ~clk;

  tcp_apb_master host (.clk(clk), .pready(pready), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  tcp_timer dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_a_out(pin_a_out), .pin_a_oe_n(pin_a_oe_n), .pin_b_out(pin_b_out),
    .pin_b_oe_n(pin_b_oe_n));

  // ------------------------------------------------------------------
  // checking, monitor and bus helpers
  // ------------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // read answers are matched against the oldest note at the edge pready is seen
  always @(posedge clk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      nt = notes.pop_front();
      check("read data", prdata & nt.mask, nt.exp);
      check("slave error", {31'h0, pslverr}, {31'h0, nt.err});
    end
  end
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] mk);
    notes.push_back('{exp: e, mask: mk, err: (a > tcp_pkg::TCP_OFS_CMPA_ACT)});
    host.xfer(1'b0, a, 32'h0000_0000);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d);
  endtask
  function automatic logic [31:0] ctl(logic [3:0] md, logic [1:0] ac, logic [2:0] pr, logic d);
    return (32'(md) << tcp_pkg::TCP_CTRL_MODE_LSB) | (32'(ac) << tcp_pkg::TCP_CTRL_ACTA_LSB)
      | (32'(pr) << tcp_pkg::TCP_CTRL_PRE_LSB) | (32'(d) << tcp_pkg::TCP_CTRL_DIRA);
  endfunction
  // one whole high phase then low phase of pin a; a stuck pin is cut off by the watchdog
  task automatic measure(output int h, output int l);
    @(negedge clk iff pin_a_out === 1'b0);
    @(negedge clk iff pin_a_out === 1'b1);
    h = 0;
    l = 0;
    while (pin_a_out === 1'b1) begin
      h++;
      @(negedge clk);
    end
    while (pin_a_out === 1'b0) begin
      l++;
      @(negedge clk);
    end
    @(posedge clk);
  endtask
  task automatic edges(input int n, output int e);
    logic last;
    @(negedge clk);
    last = pin_a_out;
    e = 0;
    repeat (n) begin
      @(negedge clk);
      if (pin_a_out !== last) e++;
      last = pin_a_out;
    end
    @(posedge clk);
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog counts from time zero, sized a little above the whole run, which the wrap through max dominates
  always @(posedge clk) begin
    cycles++;
    if (cycles == 100000) begin
      num_errors++;
      conclude();
    end
  end

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  initial begin
    void'($urandom(91750));
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd(tcp_pkg::TCP_OFS_CTRL, tcp_pkg::TCP_CTRL_RESET, '1);
    rd(tcp_pkg::TCP_OFS_FLAGS, 32'h0, '1);
    rd(tcp_pkg::TCP_OFS_CMPB, 32'h0, '1);
    rd(8'h1C, 32'h0, '1);
    check("pin a enable", {31'h0, pin_a_oe_n}, 32'h1);
    // clear-on-match, compare a top, toggling at 1 and 8 prescale
    t = 3 + $urandom_range(37);
    wr(tcp_pkg::TCP_OFS_CMPA, 32'(t));
    wr(tcp_pkg::TCP_OFS_CTRL, ctl(tcp_pkg::TCP_MODE_CTC_A, tcp_pkg::TCP_ACT_TOGGLE, 3'h1, 1'b1));
    measure(hi, lo);
    check("ctc high", 32'(hi), 32'(t + 1));
    check("ctc low", 32'(lo), 32'(t + 1));
    rd(tcp_pkg::TCP_OFS_FLAGS, 32'h2, 32'h3);
    wr(tcp_pkg::TCP_OFS_CTRL, ctl(tcp_pkg::TCP_MODE_CTC_A, tcp_pkg::TCP_ACT_TOGGLE, 3'h2, 1'b1));
    measure(hi, lo);
    measure(hi, lo);
    check("ctc prescaled", 32'(hi), 32'(8 * (t + 1)));
    wr(tcp_pkg::TCP_OFS_CTRL, ctl(tcp_pkg::TCP_MODE_CTC_A, tcp_pkg::TCP_ACT_TOGGLE, 3'h1, 1'b0));
    // the enable flop follows the control write one edge later
    @(posedge clk);
    check("pin a released", {31'h0, pin_a_oe_n}, 32'h1);
    wr(tcp_pkg::TCP_OFS_CTRL, ctl(tcp_pkg::TCP_MODE_CTC_A, tcp_pkg::TCP_ACT_NONE, 3'h1, 1'b1));
    @(posedge clk);
    check("no action enable", {31'h0, pin_a_oe_n}, 32'h1);
    edges(4 * (t + 1), c);
    check("no action edges", 32'(c), 32'h0);
    // clear-on-match, capture top; then a top written below the count
    // a new top above the old one keeps the running count below it, so nothing wraps
    t = 41 + $urandom_range(37);
    wr(tcp_pkg::TCP_OFS_CAPTOP, 32'(t));
    wr(tcp_pkg::TCP_OFS_CTRL, ctl(tcp_pkg::TCP_MODE_CTC_C, tcp_pkg::TCP_ACT_TOGGLE, 3'h1, 1'b1));
    wr(tcp_pkg::TCP_OFS_CMPA, 32'h0);
    measure(hi, lo);
    check("capture top", 32'(hi), 32'(t + 1));
    rd(tcp_pkg::TCP_OFS_FLAGS, 32'h8, 32'h9);
    wr(tcp_pkg::TCP_OFS_CAPTOP, 32'h8000);
    wr(tcp_pkg::TCP_OFS_FLAGS, 32'hF);
    repeat (100) @(posedge clk);
    wr(tcp_pkg::TCP_OFS_CAPTOP, 32'h0010);
    rd(tcp_pkg::TCP_OFS_FLAGS, 32'h0, 32'h9);
    repeat (65600) @(posedge clk);
    rd(tcp_pkg::TCP_OFS_FLAGS, 32'h9, 32'h9);
    // fast pwm with fixed tops, non-inverted
    for (int i = 0; i < 3; i++) begin
      wr(tcp_pkg::TCP_OFS_CTRL, ctl(4'(5 + i), tcp_pkg::TCP_ACT_NONINV, 3'h1, 1'b1));
      wr(tcp_pkg::TCP_OFS_CMPA, 32'hFFFF);
      rd(tcp_pkg::TCP_OFS_CMPA, 32'(tops[i]), '1);
      repeat (2 * tops[i] + 4) @(posedge clk);
      edges(tops[i] + 4, c);
      check("compare at top", 32'(c), 32'h0);
      v = 1 + $urandom_range(tops[i] - 2);
      wr(tcp_pkg::TCP_OFS_CMPA, 32'(v));
      repeat (2 * tops[i] + 4) @(posedge clk);
      measure(hi, lo);
      check("pwm high", 32'(hi), 32'(v + 1));
      check("pwm period", 32'(hi + lo), 32'(tops[i] + 1));
      wr(tcp_pkg::TCP_OFS_FLAGS, 32'hF);
      repeat (tops[i] + 2) @(posedge clk);
      rd(tcp_pkg::TCP_OFS_FLAGS, 32'h3, 32'h3);
    end
    // second reset, then the fastest toggles
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd(tcp_pkg::TCP_OFS_COUNT, 32'h0, '1);
    wr(tcp_pkg::TCP_OFS_CMPA, 32'h0);
    wr(tcp_pkg::TCP_OFS_CTRL, ctl(tcp_pkg::TCP_MODE_CTC_A, tcp_pkg::TCP_ACT_TOGGLE, 3'h1, 1'b1));
    measure(hi, lo);
    check("ctc fastest", 32'(hi + lo), 32'h2);
    wr(tcp_pkg::TCP_OFS_CTRL, ctl(tcp_pkg::TCP_MODE_FP_A, tcp_pkg::TCP_ACT_TOGGLE, 3'h1, 1'b1));
    measure(hi, lo);
    check("pwm toggle", 32'(hi + lo), 32'h2);
    // capture top kept at or above compare, inverted, compare buffering
    t = 3 + $urandom_range(37);
    v = 1 + $urandom_range(t - 2);
    wr(tcp_pkg::TCP_OFS_CAPTOP, 32'(t));
    wr(tcp_pkg::TCP_OFS_CTRL, ctl(tcp_pkg::TCP_MODE_FP_CAP, tcp_pkg::TCP_ACT_INV, 3'h1, 1'b1));
    wr(tcp_pkg::TCP_OFS_CMPA, 32'(v));
    repeat (2 * t + 4) @(posedge clk);
    measure(hi, lo);
    check("inverted low", 32'(lo), 32'(v + 1));
    check("inverted high", 32'(hi), 32'(t - v));
    wr(tcp_pkg::TCP_OFS_FLAGS, 32'hF);
    repeat (t + 2) @(posedge clk);
    rd(tcp_pkg::TCP_OFS_FLAGS, 32'hB, 32'hB);
    wr(tcp_pkg::TCP_OFS_CTRL, ctl(tcp_pkg::TCP_MODE_FP_CAP, tcp_pkg::TCP_ACT_INV, 3'h0, 1'b1));
    wr(tcp_pkg::TCP_OFS_CMPA, 32'(t));
    rd(tcp_pkg::TCP_OFS_CMPA_ACT, 32'(v), '1);
    rd(tcp_pkg::TCP_OFS_CMPA, 32'(t), '1);
    wr(tcp_pkg::TCP_OFS_CTRL, ctl(tcp_pkg::TCP_MODE_FP_CAP, tcp_pkg::TCP_ACT_INV, 3'h1, 1'b1));
    repeat (t + 3) @(posedge clk);
    rd(tcp_pkg::TCP_OFS_CMPA_ACT, 32'(t), '1);
    check("pin b idle", {30'h0, pin_b_oe_n, pin_b_out}, 32'h2);
    conclude();
  end
endmodule
